// *** inc/an_np_pkg.sv ***
/*
 * constants for the auto-negotiation expansion, next-page and indirect mmd
 * access register bank. assumes a 5-bit register index and 16-bit data words
 * as carried by the serial management port.
 */
// Functional notes
// - expansion bit 6 always reads one
// - bit 5 reads one, pages go to index 8
// - parallel fault bit 4 latches until read
// - page received bit 1 latches on new page
// - bit 3 reports partner next page ability
// - bit 2 always reads one
// - bit 0 reports partner auto-negotiation ability
// - tx page writable fields, toggle read-only
// - rx page read-only, zero after reset
// - rx bit 14 flags received code word
// - function field: 00 address, 01 data
// - device select field picks target mmd
// - address mode loads mmd register address
// - data mode moves data at latched address

package an_np_pkg;

   // -------------------------------------------------------------------
   // register indices
   // -------------------------------------------------------------------
   localparam logic [4:0] IDX_EXPANSION = 5'h06; // autoneg_expansion_status
   localparam logic [4:0] IDX_NP_TX = 5'h07; // next_page_transmit
   localparam logic [4:0] IDX_NP_RX = 5'h08; // next_page_receive
   localparam logic [4:0] IDX_MMD_CTRL = 5'h0d; // indirect_access_control
   localparam logic [4:0] IDX_MMD_ADDR_DATA = 5'h0e; // indirect_address_data

   // -------------------------------------------------------------------
   // expansion register bit positions
   // -------------------------------------------------------------------
   localparam int EXP_NP_LOC_ABLE = 6; // storage location is reported
   localparam int EXP_NP_LOC = 5; // pages kept in receive register
   localparam int EXP_PD_FAULT = 4; // latching parallel fault
   localparam int EXP_LP_NP_ABLE = 3; // partner next page able
   localparam int EXP_NP_ABLE = 2; // local next page able
   localparam int EXP_PAGE_RCVD = 1; // latching page received
   localparam int EXP_LP_AN_ABLE = 0; // partner autoneg able

   // -------------------------------------------------------------------
   // next page word layout
   // -------------------------------------------------------------------
   localparam int NP_NEXT = 15; // next page flag
   localparam int NP_ACK = 14; // acknowledge, receive side only
   localparam int NP_MSG = 13; // message page flag
   localparam int NP_ACK2 = 12; // comply acknowledge
   localparam int NP_TOGGLE = 11; // toggle
   localparam logic [15:0] NP_TX_WR_MASK = 16'hb7ff; // writable tx bits
   localparam logic [15:0] NP_TX_RESET = 16'h2001; // message page, code 1
   localparam logic [15:0] NP_RX_RESET = 16'h0000; // receive page at reset

   // -------------------------------------------------------------------
   // indirect access control layout
   // -------------------------------------------------------------------
   localparam int MMD_FUNC_HI = 15; // function field top bit
   localparam int MMD_FUNC_LO = 14; // function field low bit
   localparam int MMD_DEV_HI = 4; // device select top bit
   localparam logic [1:0] RESET_FUNC = 2'h0; // function after reset
   localparam logic [4:0] RESET_DEV = 5'h00; // device select after reset
   localparam logic [15:0] RESET_ADDR_DATA = 16'h0000; // address/data reset
   localparam logic [4:0] MMD_DEV_PCS = 5'h03; // pcs device
   localparam logic [4:0] MMD_DEV_AN = 5'h07; // autoneg device

   // function field codes
   typedef enum logic [1:0]
   {
      FUNC_ADDRESS = 2'b00, // load mmd register address
      FUNC_DATA = 2'b01, // data, no post increment
      FUNC_RSVD_A = 2'b10, // must not be written
      FUNC_RSVD_B = 2'b11 // must not be written
   } mmd_func_t;

endpackage : an_np_pkg

// *** core/lh_status_bit.sv ***
/*
 * one latching-high status bit that clears when software reads it.
 * assumes set condition and read strobe come from logic on sys_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module lh_status_bit
(
   input wire logic sys_clk, // system clock
   input wire logic srst, // synchronous reset, active high
   input wire logic set_cond, // setting condition, level
   input wire logic rd_clr, // read of the owning register, pulse
   output logic bit_q // latched status
);

   // -------------------------------------------------------------------
   // latch
   // -------------------------------------------------------------------
   // the condition wins over a read in the same cycle, so no event is lost
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         bit_q <= 1'b0;
      end
      else
      begin
         bit_q <= set_cond | (bit_q & ~rd_clr);
      end
   end

endmodule : lh_status_bit

`default_nettype wire

// *** core/an_np_regs.sv ***
/*
 * expansion status, next page tx/rx and indirect mmd access registers.
 * assumes a serial management frame decoder on sys_clk delivering one-cycle
 * read and write strobes with a register index, and an autoneg engine and
 * mmd register space on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module an_np_regs
(
   input wire logic sys_clk, // system clock, 200 mhz
   input wire logic srst, // synchronous reset, active high
   // serial_management_port register access
   input wire logic reg_wr, // write strobe, one cycle
   input wire logic reg_rd, // read strobe, one cycle
   input wire logic [4:0] reg_idx, // register index
   input wire logic [15:0] reg_wdata, // write data
   output logic [15:0] reg_rdata_q, // read data, valid cycle after reg_rd
   // autoneg engine side
   input wire logic page_rcvd, // new page arrived, pulse or level
   input wire logic pd_fault, // parallel detection fault condition
   input wire logic lp_np_able, // partner advertised next page ability
   input wire logic lp_an_able, // partner is autoneg capable
   input wire logic np_rx_load, // load a received next page, pulse
   input wire logic [15:0] np_rx_word, // received next page word
   input wire logic np_tx_toggle, // toggle bit kept by the engine
   output logic [15:0] np_tx_word_q, // next page to transmit
   // mmd register space side
   output logic [4:0] mmd_device_select_q, // selected mmd device
   output logic [15:0] mmd_addr_q, // latched mmd register address
   output logic [15:0] mmd_wdata_q, // mmd write data
   output logic mmd_wr_q, // mmd write pulse
   output logic mmd_rd_q, // mmd read pulse, for read side effects
   input wire logic [15:0] mmd_rdata // mmd data at selected address
);
   import an_np_pkg::*;

   // -------------------------------------------------------------------
   // declarations
   // -------------------------------------------------------------------
   logic [1:0] lh_set; // latching bit conditions
   logic [1:0] lh_q; // latched bits: 0 page received, 1 fault
   logic exp_rd; // expansion register is being read
   logic [15:0] np_rx_q; // received next page
   logic [1:0] func_q; // mmd function field
   logic [15:0] rdata_d; // read mux
   logic data_mode; // function field selects data

   assign exp_rd = reg_rd && (reg_idx == IDX_EXPANSION);
   assign lh_set = {pd_fault, page_rcvd};
   // reserved codes behave as data mode; software must not write them
   assign data_mode = (func_q != FUNC_ADDRESS);

   // -------------------------------------------------------------------
   // latching status bits
   // -------------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++)
      begin : g_lh
         lh_status_bit u_lh
         (
            .sys_clk(sys_clk),
            .srst(srst),
            .set_cond(lh_set[gi]),
            .rd_clr(exp_rd),
            .bit_q(lh_q[gi])
         );
      end
   endgenerate

   // -------------------------------------------------------------------
   // next page transmit register
   // -------------------------------------------------------------------
   // toggle bit is owned by the engine, so it is never stored here
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         np_tx_word_q <= NP_TX_RESET;
      end
      else if (reg_wr && reg_idx == IDX_NP_TX)
      begin
         np_tx_word_q <= reg_wdata & NP_TX_WR_MASK;
      end
   end

   // -------------------------------------------------------------------
   // next page receive register
   // -------------------------------------------------------------------
   // software writes are ignored: the engine is the only writer
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         np_rx_q <= NP_RX_RESET;
      end
      else if (np_rx_load)
      begin
         np_rx_q <= np_rx_word;
      end
   end

   // -------------------------------------------------------------------
   // indirect access control
   // -------------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         func_q <= RESET_FUNC;
         mmd_device_select_q <= RESET_DEV;
      end
      else if (reg_wr && reg_idx == IDX_MMD_CTRL)
      begin
         func_q <= reg_wdata[MMD_FUNC_HI:MMD_FUNC_LO];
         mmd_device_select_q <= reg_wdata[MMD_DEV_HI:0];
      end
   end

   // -------------------------------------------------------------------
   // indirect address / data
   // -------------------------------------------------------------------
   // the address only moves in address mode; data mode leaves it alone
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         mmd_addr_q <= RESET_ADDR_DATA;
      end
      else if (reg_wr && reg_idx == IDX_MMD_ADDR_DATA && !data_mode)
      begin
         mmd_addr_q <= reg_wdata;
      end
   end

   // data mode strobes into the mmd space at the latched address
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         mmd_wdata_q <= RESET_ADDR_DATA;
         mmd_wr_q <= 1'b0;
         mmd_rd_q <= 1'b0;
      end
      else
      begin
         mmd_wr_q <= reg_wr && reg_idx == IDX_MMD_ADDR_DATA && data_mode;
         mmd_rd_q <= reg_rd && reg_idx == IDX_MMD_ADDR_DATA && data_mode;
         if (reg_wr && reg_idx == IDX_MMD_ADDR_DATA && data_mode)
         begin
            mmd_wdata_q <= reg_wdata;
         end
      end
   end

   // -------------------------------------------------------------------
   // read mux
   // -------------------------------------------------------------------
   always_comb
   begin
      rdata_d = 16'h0000; // unmapped and reserved bits read zero
      if (reg_idx == IDX_EXPANSION)
      begin
         rdata_d[EXP_NP_LOC_ABLE] = 1'b1;
         rdata_d[EXP_NP_LOC] = 1'b1;
         rdata_d[EXP_PD_FAULT] = lh_q[1];
         rdata_d[EXP_LP_NP_ABLE] = lp_np_able;
         rdata_d[EXP_NP_ABLE] = 1'b1;
         rdata_d[EXP_PAGE_RCVD] = lh_q[0];
         rdata_d[EXP_LP_AN_ABLE] = lp_an_able;
      end
      else if (reg_idx == IDX_NP_TX)
      begin
         rdata_d = np_tx_word_q;
         rdata_d[NP_TOGGLE] = np_tx_toggle;
      end
      else if (reg_idx == IDX_NP_RX)
      begin
         rdata_d = np_rx_q;
      end
      else if (reg_idx == IDX_MMD_CTRL)
      begin
         rdata_d[MMD_FUNC_HI:MMD_FUNC_LO] = func_q;
         rdata_d[MMD_DEV_HI:0] = mmd_device_select_q;
      end
      else if (reg_idx == IDX_MMD_ADDR_DATA)
      begin
         // address mode shows the latched address, data mode the mmd word
         rdata_d = data_mode ? mmd_rdata : mmd_addr_q;
      end
   end

   // read data holds until the next read
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         reg_rdata_q <= 16'h0000;
      end
      else if (reg_rd)
      begin
         reg_rdata_q <= rdata_d;
      end
   end

   // -------------------------------------------------------------------
   // assertions
   // -------------------------------------------------------------------
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (srst);

   chk_exp_fixed_ones: assert property (exp_rd |=> reg_rdata_q[6] && reg_rdata_q[5])
      else $error("expansion location bits not one");
   chk_np_storage: assert property (np_rx_load && !reg_rd ##1 reg_rd && reg_idx == IDX_NP_RX
      |=> reg_rdata_q == $past(np_rx_word, 2))
      else $error("received page not in receive register");
   chk_fault_latch: assert property (pd_fault ##1 (!exp_rd && !pd_fault)[*2] ##1 exp_rd
      |=> reg_rdata_q[EXP_PD_FAULT])
      else $error("parallel fault not held until read");
   chk_page_latch: assert property (page_rcvd ##1 exp_rd |=> reg_rdata_q[EXP_PAGE_RCVD])
      else $error("page received not latched");
   chk_lh_clear: assert property (exp_rd && !page_rcvd && !pd_fault ##1 !page_rcvd
      && !pd_fault ##1 exp_rd |=> reg_rdata_q[4] == 1'b0 && reg_rdata_q[1] == 1'b0)
      else $error("latched bits not cleared by read");
   chk_lp_np: assert property (exp_rd |=> reg_rdata_q[EXP_LP_NP_ABLE] == $past(lp_np_able))
      else $error("partner next page bit wrong");
   chk_np_able: assert property (exp_rd |=> reg_rdata_q[EXP_NP_ABLE])
      else $error("local next page bit not one");
   chk_lp_an: assert property (exp_rd |=> reg_rdata_q[EXP_LP_AN_ABLE] == $past(lp_an_able))
      else $error("partner autoneg bit wrong");
   chk_tx_write: assert property (reg_wr && reg_idx == IDX_NP_TX
      |=> np_tx_word_q == ($past(reg_wdata) & 16'hb7ff))
      else $error("tx page write wrong");
   chk_rx_readonly: assert property (reg_wr && reg_idx == IDX_NP_RX && !np_rx_load
      |=> $stable(np_rx_q))
      else $error("rx page changed by write");
   chk_rx_ack: assert property (np_rx_load && np_rx_word[NP_ACK] |=> np_rx_q[NP_ACK])
      else $error("rx acknowledge not captured");
   chk_ctrl_write: assert property (reg_wr && reg_idx == IDX_MMD_CTRL
      |=> func_q == $past(reg_wdata[15:14]) && mmd_device_select_q == $past(reg_wdata[4:0]))
      else $error("control fields not written");
   chk_addr_mode: assert property (reg_wr && reg_idx == IDX_MMD_ADDR_DATA && func_q == 2'b00
      |=> mmd_addr_q == $past(reg_wdata) && !mmd_wr_q)
      else $error("address mode did not load address");
   chk_data_write: assert property (reg_wr && reg_idx == IDX_MMD_ADDR_DATA
      && func_q != 2'b00 |=> mmd_wr_q && mmd_wdata_q == $past(reg_wdata) && $stable(mmd_addr_q)
      ##1 (!mmd_wr_q || $past(reg_wr)))
      else $error("data mode write wrong");

   cov_page_then_read: cover property (page_rcvd ##[1:4] exp_rd);
   cov_mmd_write: cover property (reg_wr && reg_idx == IDX_MMD_ADDR_DATA ##[1:8] mmd_wr_q);
   cov_mmd_read: cover property (mmd_rd_q);
   cov_np_load: cover property (np_rx_load ##[1:8] reg_rd && reg_idx == IDX_NP_RX);

endmodule : an_np_regs

`default_nettype wire

// *** test/mmd_space_model.sv ***
/*
 * behavioural mmd register space that answers the indirect access port.
 * assumes select, address, data and write pulse come registered on sys_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module mmd_space_model
(
   input wire logic sys_clk, // system clock
   input wire logic srst, // synchronous reset, active high
   input wire logic [4:0] dev_sel, // selected mmd device
   input wire logic [15:0] addr, // latched register address
   input wire logic [15:0] wdata, // write data
   input wire logic wr, // write pulse
   output logic [15:0] rdata // word at the selected place
);
   // -------------------------------------------------------------------
   // storage keyed by device bit 2 and the address low nibble
   // -------------------------------------------------------------------
   logic [15:0] mem_q [32]; // stored words
   logic [31:0] used_q; // place written since reset
   logic [4:0] key; // storage index
   // narrow key is a limitation: the bench keeps its keys apart
   assign key = {dev_sel[2], addr[3:0]};

   // writes land on the pulse only
   always_ff @(posedge sys_clk)
   begin
      if (srst)
         used_q <= 32'h0;
      else if (wr)
      begin
         mem_q[key] <= wdata;
         used_q[key] <= 1'b1;
      end
   end

   // unwritten places answer a pattern, never a stale word
   always_comb
   begin
      rdata = addr ^ {dev_sel, 11'h5a5};
      if (used_q[key])
         rdata = mem_q[key];
   end
endmodule : mmd_space_model
`default_nettype wire

// *** test/an_np_regs_test.sv ***
/*
 * self-checking bench for an_np_regs with random and corner traffic.
 * assumes mmd_space_model stands on the indirect data side.
 */
`timescale 1ns/1ps
`default_nettype none

module an_np_regs_test;
   import an_np_pkg::*;
   // -------------------------------------------------------------------
   // stimulus and wiring
   // -------------------------------------------------------------------
   logic sys_clk = 1'b0; // 200 mhz
   logic srst = 1'b1; // held four cycles
   logic reg_wr = 1'b0; // write strobe
   logic reg_rd = 1'b0; // read strobe
   logic [4:0] reg_idx = 5'h00; // register index
   logic [15:0] reg_wdata = 16'h0000; // write data
   logic page_rcvd = 1'b0; // page condition
   logic pd_fault = 1'b0; // fault condition
   logic lp_np_able = 1'b0; // partner next page able
   logic lp_an_able = 1'b0; // partner autoneg able
   logic np_rx_load = 1'b0; // rx page load pulse
   logic [15:0] np_rx_word = 16'h0000; // rx page word
   logic np_tx_toggle = 1'b0; // engine toggle
   logic [15:0] reg_rdata_q, np_tx_word_q, mmd_addr_q, mmd_wdata_q, mmd_rdata; // outputs
   logic [4:0] mmd_device_select_q; // selected device
   logic mmd_wr_q, mmd_rd_q; // mmd write and read pulses
   logic [15:0] v, w, a; // scratch words
   logic [4:0] dev; // device under test
   int fails = 0; // mismatches
   int n_compared = 0; // comparisons

   an_np_regs u_an_np_regs (.sys_clk(sys_clk), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_idx(reg_idx), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
      .page_rcvd(page_rcvd), .pd_fault(pd_fault), .lp_np_able(lp_np_able),
      .lp_an_able(lp_an_able), .np_rx_load(np_rx_load), .np_rx_word(np_rx_word),
      .np_tx_toggle(np_tx_toggle), .np_tx_word_q(np_tx_word_q),
      .mmd_device_select_q(mmd_device_select_q), .mmd_addr_q(mmd_addr_q),
      .mmd_wdata_q(mmd_wdata_q), .mmd_wr_q(mmd_wr_q), .mmd_rd_q(mmd_rd_q), .mmd_rdata(mmd_rdata));
   mmd_space_model u_mmd_space_model (.sys_clk(sys_clk), .srst(srst),
      .dev_sel(mmd_device_select_q), .addr(mmd_addr_q), .wdata(mmd_wdata_q), .wr(mmd_wr_q),
      .rdata(mmd_rdata));

   // clock: 5 ns period
   initial
   begin
      forever #2.5 sys_clk = ~sys_clk;
   end

   // -------------------------------------------------------------------
   // expectations and bus tasks
   // -------------------------------------------------------------------
   function automatic logic [15:0] exp_expansion(input logic np, an, pf, pr);
      exp_expansion = 16'h0000;
      exp_expansion[EXP_NP_LOC_ABLE] = 1'b1;
      exp_expansion[EXP_NP_LOC] = 1'b1;
      exp_expansion[EXP_NP_ABLE] = 1'b1;
      exp_expansion[EXP_LP_NP_ABLE] = np;
      exp_expansion[EXP_LP_AN_ABLE] = an;
      exp_expansion[EXP_PD_FAULT] = pf;
      exp_expansion[EXP_PAGE_RCVD] = pr;
   endfunction : exp_expansion

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp)
      begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // each access leaves an idle cycle so no strobe is assigned twice at once
   task automatic wr(input logic [4:0] idx, input logic [15:0] d);
      @(posedge sys_clk);
      #1;
      reg_wr = 1'b1;
      reg_idx = idx;
      reg_wdata = d;
      @(posedge sys_clk);
      #1;
      reg_wr = 1'b0;
   endtask : wr

   task automatic rd(input logic [4:0] idx, output logic [15:0] d);
      @(posedge sys_clk);
      #1;
      reg_rd = 1'b1;
      reg_idx = idx;
      @(posedge sys_clk);
      #1;
      reg_rd = 1'b0;
      d = reg_rdata_q;
   endtask : rd

   task automatic final_report;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : final_report

   // watchdog: the tests need well under a thousand cycles
   initial
   begin
      repeat (5000) @(posedge sys_clk);
      fails++;
      final_report();
   end

   // -------------------------------------------------------------------
   // main sequence
   // -------------------------------------------------------------------
   initial
   begin
      void'($urandom(32'h69ab));
      repeat (4) @(posedge sys_clk);
      #1;
      srst = 1'b0;
      // values after reset, unmapped index included
      rd(IDX_EXPANSION, v);
      chk("expansion reset", exp_expansion(0, 0, 0, 0), v);
      rd(IDX_NP_TX, v);
      chk("tx reset", NP_TX_RESET, v);
      rd(IDX_NP_RX, v);
      chk("rx reset", NP_RX_RESET, v);
      rd(IDX_MMD_CTRL, v);
      chk("ctrl reset", 16'h0000, v);
      rd(IDX_MMD_ADDR_DATA, v);
      chk("addr data reset", RESET_ADDR_DATA, v);
      rd(5'h1f, v);
      chk("unmapped", 16'h0000, v);
      // random partner state, tx writes and rx loads; writes to read-only places
      for (int i = 0; i < 8; i++)
      begin
         lp_np_able = 1'($urandom());
         lp_an_able = 1'($urandom());
         np_tx_toggle = 1'($urandom());
         w = 16'($urandom());
         wr(IDX_NP_TX, w);
         chk("tx word", w & NP_TX_WR_MASK, np_tx_word_q);
         rd(IDX_NP_TX, v);
         chk("tx read", (w & NP_TX_WR_MASK) | {4'h0, np_tx_toggle, 11'h0}, v);
         a = 16'($urandom());
         a[NP_ACK] = i[0];
         np_rx_load = 1'b1;
         np_rx_word = a;
         @(posedge sys_clk);
         #1;
         // read in the very next cycle: the fresh page must already stand there
         np_rx_load = 1'b0;
         reg_rd = 1'b1;
         reg_idx = IDX_NP_RX;
         @(posedge sys_clk);
         #1;
         reg_rd = 1'b0;
         chk("rx at once", a, reg_rdata_q);
         wr(IDX_NP_RX, ~a);
         wr(IDX_EXPANSION, 16'hffff);
         rd(IDX_NP_RX, v);
         chk("rx read", a, v);
         rd(IDX_EXPANSION, v);
         chk("expansion", exp_expansion(lp_np_able, lp_an_able, 0, 0), v);
      end
      // latched bits: condition present at a read keeps the bit, absent clears it
      for (int j = 0; j < 2; j++)
      begin
         {pd_fault, page_rcvd} = j[0] ? 2'b10 : 2'b01;
         @(posedge sys_clk);
         #1;
         rd(IDX_EXPANSION, v);
         chk("latch held", exp_expansion(lp_np_able, lp_an_able, j[0], !j[0]), v);
         {pd_fault, page_rcvd} = 2'b00;
         // two quiet cycles before the next read, so the hold is seen across a gap
         @(posedge sys_clk);
         rd(IDX_EXPANSION, v);
         chk("latch kept", exp_expansion(lp_np_able, lp_an_able, j[0], !j[0]), v);
         rd(IDX_EXPANSION, v);
         chk("latch clear", exp_expansion(lp_np_able, lp_an_able, 0, 0), v);
      end
      // indirect access on both named devices, keys kept apart for the model
      for (int k = 0; k < 6; k++)
      begin
         dev = (k < 3) ? MMD_DEV_PCS : MMD_DEV_AN;
         a = {12'($urandom()), 4'(k)};
         w = 16'($urandom());
         wr(IDX_MMD_CTRL, {FUNC_ADDRESS, 9'h000, dev});
         wr(IDX_MMD_ADDR_DATA, a);
         chk("addr latched", a, mmd_addr_q);
         chk("no pulse in address mode", 16'h0000, {15'h0000, mmd_wr_q});
         rd(IDX_MMD_ADDR_DATA, v);
         chk("addr read", a, v);
         chk("no read pulse in address mode", 16'h0000, {15'h0000, mmd_rd_q});
         wr(IDX_MMD_CTRL, {FUNC_DATA, 9'h000, dev});
         rd(IDX_MMD_CTRL, v);
         chk("ctrl read", {FUNC_DATA, 9'h000, dev}, v);
         chk("device select", {11'h000, dev}, {11'h000, mmd_device_select_q});
         rd(IDX_MMD_ADDR_DATA, v);
         chk("blank data", a ^ {dev, 11'h5a5}, v);
         chk("mmd read pulse", 16'h0001, {15'h0000, mmd_rd_q});
         wr(IDX_MMD_ADDR_DATA, w);
         chk("mmd pulse", 16'h0001, {15'h0000, mmd_wr_q});
         chk("mmd wdata", w, mmd_wdata_q);
         chk("addr unchanged", a, mmd_addr_q);
         rd(IDX_MMD_ADDR_DATA, v);
         chk("data read", w, v);
      end
      final_report();
   end
endmodule : an_np_regs_test
`default_nettype wire
